/* adfpm_defines.vh */
// Constants for the decimation filter, high-pass stage and power-on mute
`ifndef ADFPM_DEFINES_VH
`define ADFPM_DEFINES_VH

// =====================================================================
// Datapath
// =====================================================================
`define ADFPM_DW          24
`define ADFPM_ACC_W       32
`define ADFPM_HPF_SHIFT   11
`define ADFPM_ZERO_WORD   24'h000000
`define ADFPM_ZERO_ACC    32'h00000000

// =====================================================================
// Rate classes
// =====================================================================
`define ADFPM_RATE_SINGLE 2'h0
`define ADFPM_RATE_DUAL   2'h1
`define ADFPM_RATE_QUAD   2'h2

`define ADFPM_RATIO_SINGLE 3'h7
`define ADFPM_RATIO_DUAL   3'h3
`define ADFPM_RATIO_QUAD   3'h1

`define ADFPM_GAIN_SINGLE 5
`define ADFPM_GAIN_DUAL   4
`define ADFPM_GAIN_QUAD   3

// =====================================================================
// Power-on mute timing
// =====================================================================
`define ADFPM_MCLK_PER_FS   8'hFF
`define ADFPM_MUTE_SAMPLES  6'h1F
`define ADFPM_DIV_ZERO      8'h00
`define ADFPM_CNT_ZERO      6'h00

`endif

/* adfpm_hpf.v */
// First-order DC-removing high-pass stage with bypass
`timescale 1ns/1ps
`include "adfpm_defines.vh"

module adfpm_hpf (
    input  wire                     sys_clk,
    input  wire                     rst,
    input  wire                     hpf_en,
    input  wire                     in_valid,
    input  wire [`ADFPM_DW-1:0]     in_data,
    output wire                     out_valid,
    output wire [`ADFPM_DW-1:0]     out_data
);

    reg  [`ADFPM_DW-1:0] x_prev_ff;
    reg  [`ADFPM_DW-1:0] y_prev_ff;
    reg  [`ADFPM_DW-1:0] out_ff;
    reg                  out_valid_ff;
    reg  [`ADFPM_DW+1:0] nxt_y;
    wire [`ADFPM_DW+1:0] x_ext;
    wire [`ADFPM_DW+1:0] xp_ext;
    wire [`ADFPM_DW+1:0] yp_ext;
    wire [`ADFPM_DW+1:0] yp_leak;
    reg  [`ADFPM_DW-1:0] y_sat;

    assign x_ext   = {{2{in_data[`ADFPM_DW-1]}}, in_data};
    assign xp_ext  = {{2{x_prev_ff[`ADFPM_DW-1]}}, x_prev_ff};
    assign yp_ext  = {{2{y_prev_ff[`ADFPM_DW-1]}}, y_prev_ff};
    assign yp_leak = $signed(yp_ext) >>> `ADFPM_HPF_SHIFT;

    // =================================================================
    // y[n] = x[n] - x[n-1] + y[n-1] - y[n-1]/2^11, corner near 3.7 Hz at 48 kHz
    // =================================================================
    always @* begin
        nxt_y = x_ext - xp_ext + yp_ext - yp_leak; // [R8]
        if (nxt_y[`ADFPM_DW+1] && nxt_y[`ADFPM_DW-1+:2] != 2'h3) begin
            y_sat = {1'b1, {(`ADFPM_DW-1){1'b0}}};
        end else if (!nxt_y[`ADFPM_DW+1] && nxt_y[`ADFPM_DW-1+:2] != 2'h0) begin
            y_sat = {1'b0, {(`ADFPM_DW-1){1'b1}}};
        end else begin
            y_sat = nxt_y[`ADFPM_DW-1:0];
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            x_prev_ff    <= `ADFPM_ZERO_WORD;
            y_prev_ff    <= `ADFPM_ZERO_WORD;
            out_ff       <= `ADFPM_ZERO_WORD;
            out_valid_ff <= 1'b0;
        end else begin
            out_valid_ff <= in_valid;
            if (in_valid) begin
                x_prev_ff <= in_data;
                // Filter state keeps tracking when bypassed so re-enabling has no step
                y_prev_ff <= y_sat;
                out_ff    <= hpf_en ? y_sat : in_data; // [R9]
            end
        end
    end

    assign out_valid = out_valid_ff;
    assign out_data  = out_ff;

endmodule

/* adfpm_top.v */
// Decimation filter chain, DC high-pass, serial output with power-on mute
//
// Operation
// [R1] The internal reset sequence starts on power-on or core supply power-up with no external reset pin.
// [R2] While internal reset is asserted every serial output bit is zero.
// [R3] After power-up the serial output stays zero for a further 32 sample periods.
// [R4] The mute count is timed from the master clock only, never from the frame clock.
// [R5] Single rate uses its own decimation coefficient set with 32/fs group delay class.
// [R6] Dual rate uses its own coefficient set with the same passband edge and rejection class.
// [R7] Quad rate uses its own shorter coefficient set with the 10/fs delay class.
// [R8] The enabled high-pass stage has its -3 dB corner near 3.7 Hz.
// [R9] The high-pass stage can be inserted into or removed from the sample path.
// [R10] Samples are carried as 24-bit two's complement words.
// [R11] Each serial output bit changes only on a falling edge of the bit clock.
// [R12] Every reset restarts the mute count from zero and release waits for the full count.
// [R13] The rate class selects the coefficient set and decimation ratio together.
`timescale 1ns/1ps
`include "adfpm_defines.vh"

module adfpm_top (
    input  wire                 sys_clk,
    input  wire                 rst,
    input  wire [1:0]           rate_sel,
    input  wire                 hpf_en,
    input  wire                 mod_valid,
    input  wire [`ADFPM_DW-1:0] mod_data,
    input  wire                 bclk_pin,
    input  wire                 lrclk_pin,
    output wire                 sdout,
    output wire                 mute_active,
    output wire                 sample_valid,
    output wire [`ADFPM_DW-1:0] sample_data
);

    // =================================================================
    // Pin synchronisers
    // =================================================================
    reg bclk_s1_ff;
    reg bclk_s2_ff;
    reg bclk_s3_ff;
    reg lrclk_s1_ff;
    reg lrclk_s2_ff;
    reg lrclk_s3_ff;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bclk_s1_ff  <= 1'b0;
            bclk_s2_ff  <= 1'b0;
            bclk_s3_ff  <= 1'b0;
            lrclk_s1_ff <= 1'b0;
            lrclk_s2_ff <= 1'b0;
            lrclk_s3_ff <= 1'b0;
        end else begin
            bclk_s1_ff  <= bclk_pin;
            bclk_s2_ff  <= bclk_s1_ff;
            bclk_s3_ff  <= bclk_s2_ff;
            lrclk_s1_ff <= lrclk_pin;
            lrclk_s2_ff <= lrclk_s1_ff;
            lrclk_s3_ff <= lrclk_s2_ff;
        end
    end

    wire bclk_fall = bclk_s3_ff & ~bclk_s2_ff;
    wire lr_edge   = lrclk_s3_ff ^ lrclk_s2_ff;

    // =================================================================
    // Power-on mute counter
    // =================================================================
    reg [7:0] div_ff;
    reg [5:0] smp_cnt_ff;
    reg       mute_ff;

    // rst models the internal power-on detector; no pin can clear mute early
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_ff     <= `ADFPM_DIV_ZERO; // [R12]
            smp_cnt_ff <= `ADFPM_CNT_ZERO; // [R12]
            mute_ff    <= 1'b1; // [R1]
        end else if (mute_ff) begin
            if (div_ff == `ADFPM_MCLK_PER_FS) begin // [R4]
                div_ff <= `ADFPM_DIV_ZERO;
                if (smp_cnt_ff == `ADFPM_MUTE_SAMPLES) begin
                    mute_ff <= 1'b0; // [R3]
                end else begin
                    smp_cnt_ff <= smp_cnt_ff + 6'h01;
                end
            end else begin
                div_ff <= div_ff + 8'h01;
            end
        end
    end

    // =================================================================
    // Decimation filter: per-rate coefficient set and ratio
    // =================================================================
    function [3:0] coef_of;
        input [1:0] rate;
        input [2:0] tap;
        begin
            case (rate)
                `ADFPM_RATE_DUAL: begin
                    coef_of = (tap == 3'h0 || tap == 3'h3) ? 4'h3 : 4'h5; // [R6]
                end
                `ADFPM_RATE_QUAD: begin
                    coef_of = 4'h4; // [R7]
                end
                default: begin
                    case (tap)
                        3'h0, 3'h7: coef_of = 4'h1; // [R5]
                        3'h1, 3'h6: coef_of = 4'h3;
                        3'h2, 3'h5: coef_of = 4'h5;
                        default:    coef_of = 4'h7;
                    endcase
                end
            endcase
        end
    endfunction

    reg  [1:0]              rate_ff;
    reg  [2:0]              tap_ff;
    reg  [`ADFPM_ACC_W-1:0] acc_ff;
    reg                     dec_valid_ff;
    reg  [`ADFPM_DW-1:0]    dec_data_ff;
    reg  [2:0]              last_tap;
    reg  [`ADFPM_ACC_W-1:0] nxt_acc;
    reg  [`ADFPM_ACC_W-1:0] scaled;
    wire [28:0]             prod;

    assign prod = $signed(mod_data) * $signed({1'b0, coef_of(rate_ff, tap_ff)});

    always @* begin
        nxt_acc = acc_ff + {{3{prod[28]}}, prod};
        case (rate_ff)
            `ADFPM_RATE_DUAL: begin
                last_tap = `ADFPM_RATIO_DUAL; // [R13]
                scaled   = $signed(nxt_acc) >>> `ADFPM_GAIN_DUAL;
            end
            `ADFPM_RATE_QUAD: begin
                last_tap = `ADFPM_RATIO_QUAD; // [R13]
                scaled   = $signed(nxt_acc) >>> `ADFPM_GAIN_QUAD;
            end
            default: begin
                last_tap = `ADFPM_RATIO_SINGLE; // [R13]
                scaled   = $signed(nxt_acc) >>> `ADFPM_GAIN_SINGLE;
            end
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_ff      <= `ADFPM_RATE_SINGLE;
            tap_ff       <= 3'h0;
            acc_ff       <= `ADFPM_ZERO_ACC;
            dec_valid_ff <= 1'b0;
            dec_data_ff  <= `ADFPM_ZERO_WORD;
        end else begin
            dec_valid_ff <= 1'b0;
            rate_ff      <= rate_sel;
            if (rate_ff != rate_sel) begin
                // A rate change drops the half-built output word
                tap_ff <= 3'h0;
                acc_ff <= `ADFPM_ZERO_ACC;
            end else if (mod_valid) begin
                if (tap_ff == last_tap) begin
                    tap_ff       <= 3'h0;
                    acc_ff       <= `ADFPM_ZERO_ACC;
                    dec_valid_ff <= 1'b1;
                    dec_data_ff  <= scaled[`ADFPM_DW-1:0]; // [R10]
                end else begin
                    tap_ff <= tap_ff + 3'h1;
                    acc_ff <= nxt_acc;
                end
            end
        end
    end

    // =================================================================
    // High-pass stage
    // =================================================================
    wire                 hpf_valid;
    wire [`ADFPM_DW-1:0] hpf_data;

    adfpm_hpf u_hpf (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .hpf_en    (hpf_en),
        .in_valid  (dec_valid_ff),
        .in_data   (dec_data_ff),
        .out_valid (hpf_valid),
        .out_data  (hpf_data)
    );

    // =================================================================
    // Serial output
    // =================================================================
    reg                 word_valid_ff;
    reg [`ADFPM_DW-1:0] word_ff;
    reg [`ADFPM_DW-1:0] shift_ff;
    reg                 sdout_ff;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word_valid_ff <= 1'b0;
            word_ff       <= `ADFPM_ZERO_WORD;
            shift_ff      <= `ADFPM_ZERO_WORD;
            sdout_ff      <= 1'b0; // [R2]
        end else begin
            word_valid_ff <= hpf_valid;
            if (hpf_valid) begin
                word_ff <= hpf_data;
            end
            if (lr_edge) begin
                // Muted words are loaded as zero so no stale data leaks after release
                shift_ff <= mute_ff ? `ADFPM_ZERO_WORD : word_ff; // [R3]
            end else if (bclk_fall) begin
                sdout_ff <= mute_ff ? 1'b0 : shift_ff[`ADFPM_DW-1]; // [R11]
                shift_ff <= {shift_ff[`ADFPM_DW-2:0], 1'b0};
            end
        end
    end

    assign sdout        = sdout_ff;
    assign mute_active  = mute_ff;
    assign sample_valid = word_valid_ff;
    assign sample_data  = word_ff;

endmodule

/* adfpm_props.sv */
// Port checks on mute timing, serial bit timing and filter output
`timescale 1ns/1ps
`include "adfpm_defines.vh"
module adfpm_props (
    input wire                 sys_clk,
    input wire                 rst,
    input wire [1:0]           rate_sel,
    input wire                 hpf_en,
    input wire                 mod_valid,
    input wire [`ADFPM_DW-1:0] mod_data,
    input wire                 bclk_pin,
    input wire                 lrclk_pin,
    input wire                 sdout,
    input wire                 mute_active,
    input wire                 sample_valid,
    input wire [`ADFPM_DW-1:0] sample_data
);
    // ========
    // Helpers
    // ========
    // Clock cycles since reset, saturating at the mute length
    reg [13:0] cnt_ff;
    reg [5:0]  fall_ff;
    reg        bclk_ff;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_ff  <= 14'h0000;
            fall_ff <= 6'h00;
            bclk_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + {13'h0000, cnt_ff < 14'h2000};
            fall_ff <= {fall_ff[4:0], bclk_ff & ~bclk_pin};
            bclk_ff <= bclk_pin;
        end
    end
    // ========
    // Properties
    // ========
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_release;
        $fell(mute_active);
    endsequence
    sequence s_new_bit;
        $changed(sdout);
    endsequence
    a_mute_zero: assert property (mute_active |-> !sdout)
        else $error("sdout high while muted");
    a_mute_length: assert property (mute_active == (cnt_ff < 14'h2000))
        else $error("mute length wrong");
    a_mute_stays_off: assert property (!mute_active |=> !mute_active)
        else $error("mute came back without reset");
    a_release_time: assert property (s_release |-> cnt_ff == 14'h2000)
        else $error("mute released early or late");
    a_bit_on_fall: assert property (s_new_bit |-> fall_ff != 6'h00)
        else $error("sdout changed without bit clock fall");
    a_valid_cause: assert property (sample_valid |-> $past(mod_valid, 2) || $past(mod_valid, 3))
        else $error("sample_valid without input");
    a_data_holds: assert property ($changed(sample_data) |-> sample_valid)
        else $error("sample_data changed without valid");
    a_valid_pulse: assert property (sample_valid |=> !sample_valid)
        else $error("sample_valid longer than one cycle");
endmodule
bind adfpm_top adfpm_props u_props (.sys_clk(sys_clk), .rst(rst), .rate_sel(rate_sel), .hpf_en(hpf_en),
    .mod_valid(mod_valid), .mod_data(mod_data), .bclk_pin(bclk_pin), .lrclk_pin(lrclk_pin), .sdout(sdout),
    .mute_active(mute_active), .sample_valid(sample_valid), .sample_data(sample_data));

/* adfpm_rx_model.sv */
// Serial receiver model that masters the bit and frame clocks
`timescale 1ns/1ps
module adfpm_rx_model (
    input  wire        sys_clk,
    input  wire        run,
    input  wire        sdout,
    output reg         bclk_pin,
    output reg         lrclk_pin,
    output reg  [23:0] rx_word,
    output reg         rx_done
);
    // ========
    // Frame sequencer
    // ========
    // Halves of 6 cycles leave room for the device's 3-cycle pin sync
    reg [8:0] ph_ff;
    wire      in_bits = run && ph_ff >= 9'h008 && ph_ff < 9'h128;
    initial begin
        bclk_pin = 1'b1;
        lrclk_pin = 1'b0;
        rx_word = 24'h000000;
        rx_done = 1'b0;
        ph_ff = 9'h000;
    end
    always @(posedge sys_clk) begin
        rx_done <= 1'b0;
        ph_ff <= (!run || ph_ff == 9'h12C) ? 9'h000 : ph_ff + 9'h001;
        // Park the bit clock high between runs, else the first fall of the next run is lost
        if (!run)
            bclk_pin <= 1'b1;
        if (run && ph_ff == 9'h000)
            lrclk_pin <= ~lrclk_pin;
        if (in_bits && (ph_ff - 9'h008) % 12 == 0)
            bclk_pin <= 1'b0;
        if (in_bits && (ph_ff - 9'h008) % 12 == 6) begin
            bclk_pin <= 1'b1;
            rx_word <= {rx_word[22:0], sdout};
        end
        if (run && ph_ff == 9'h129)
            rx_done <= 1'b1;
    end
endmodule

/* tb_top.sv */
// Self-checking bench for the decimation filter with power-on mute
`timescale 1ns/1ps
`include "adfpm_defines.vh"
module tb_top;
    reg                  sys_clk, rst, hpf_en, mod_valid, run;
    reg  [1:0]           rate_sel;
    reg  [`ADFPM_DW-1:0] mod_data;
    wire                 bclk_pin, lrclk_pin, sdout, mute_active, sample_valid, rx_done;
    wire [`ADFPM_DW-1:0] sample_data, rx_word;
    integer              seed = 32'hC82701E5;
    int                  miscompares = 0, checks_done = 0, g;
    logic [23:0]         sq[$];
    logic [23:0]         x1, y1, exp_y;
    logic [1:0]          cur_rate;
    logic                hpf_cur;
    adfpm_top uut (.sys_clk(sys_clk), .rst(rst), .rate_sel(rate_sel), .hpf_en(hpf_en), .mod_valid(mod_valid),
        .mod_data(mod_data), .bclk_pin(bclk_pin), .lrclk_pin(lrclk_pin), .sdout(sdout), .mute_active(mute_active),
        .sample_valid(sample_valid), .sample_data(sample_data));
    adfpm_rx_model u_rx (.sys_clk(sys_clk), .run(run), .sdout(sdout), .bclk_pin(bclk_pin),
        .lrclk_pin(lrclk_pin), .rx_word(rx_word), .rx_done(rx_done));
    // ========
    // Clock, watchdog, reporting
    // ========
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        miscompares++;
        test_done;
    end
    task test_done;
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input [23:0] e, input [23:0] v);
        checks_done++;
        if (v !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, v);
        end
    endtask
    // ========
    // Expected values
    // ========
    function automatic int nr(input [1:0] r);
        return (r == `ADFPM_RATE_QUAD) ? 2 : (r == `ADFPM_RATE_DUAL) ? 4 : 8;
    endfunction
    function automatic int wt(input [1:0] r, input int i);
        return (r == `ADFPM_RATE_QUAD) ? 4 : (r == `ADFPM_RATE_DUAL) ? ((i == 0 || i == 3) ? 3 : 5)
            : ((i < 4) ? 2 * i + 1 : 15 - 2 * i);
    endfunction
    function automatic [23:0] dec(input [1:0] r);
        int a = 0;
        foreach (sq[i]) a = a + wt(r, i) * $signed(sq[i]);
        return a >>> ((r == `ADFPM_RATE_QUAD) ? `ADFPM_GAIN_QUAD : (r == `ADFPM_RATE_DUAL) ? `ADFPM_GAIN_DUAL
            : `ADFPM_GAIN_SINGLE);
    endfunction
    // ========
    // Drivers
    // ========
    // The high-pass state follows every word, bypassed or not
    task put(input bit v, input [23:0] d);
        int t;
        logic [23:0] xw;
        @(posedge sys_clk);
        mod_valid <= v;
        mod_data <= d;
        if (v)
            sq.push_back(d);
        if (sq.size() == nr(cur_rate)) begin
            xw = dec(cur_rate);
            sq.delete();
            t = $signed(xw) - $signed(x1) + $signed(y1) - ($signed(y1) >>> `ADFPM_HPF_SHIFT);
            t = (t > 8388607) ? 8388607 : (t < -8388608) ? -8388608 : t;
            exp_y = hpf_cur ? t[23:0] : xw;
            x1 = xw;
            y1 = t[23:0];
        end
    endtask
    task wait_on(input bit sel, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge sys_clk);
            if ((sel ? rx_done : sample_valid) === 1'b1)
                break;
        end
        chk("handshake", 24'h000001, {23'h0, sel ? rx_done : sample_valid});
    endtask
    task do_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        mod_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("sdout in reset", 24'h000000, {23'h0, sdout});
        @(posedge sys_clk);
        rst <= 1'b0;
        sq.delete();
        x1 = 24'h000000;
        y1 = 24'h000000;
    endtask
    // Random input keeps the filter busy so forced zeros mean something
    task mute_phase(input int len);
        for (int k = 1; k <= len; k++) begin
            put(k > 1 && ($random(seed) & 1), $random(seed));
            @(negedge sys_clk);
            if (k == 8191 || k == 8192)
                chk("mute_active", {23'h0, k == 8191}, {23'h0, mute_active});
            if (run && rx_done === 1'b1 && k < 8000)
                chk("muted rx_word", 24'h000000, rx_word);
        end
        put(1'b0, 24'h000000);
    endtask
    // A junk group leaves a partial sum and a dropped sample behind
    task group(input [1:0] r, input bit h, input bit junk, input bit big);
        if (junk)
            put(1'b1, $random(seed));
        @(posedge sys_clk);
        rate_sel <= r;
        hpf_en <= h;
        mod_valid <= junk;
        if (r != cur_rate)
            sq.delete();
        cur_rate = r;
        hpf_cur = h;
        repeat (2) put(1'b0, 24'h000000);
        for (int i = 0; i < nr(r); i++)
            put(1'b1, big ? 24'h7FFFFF : $random(seed));
        put(1'b0, 24'h000000);
        wait_on(1'b0, 8);
        chk("sample_data", exp_y, sample_data);
        repeat (2) wait_on(1'b1, 700);
        chk("rx_word", exp_y, rx_word);
    endtask
    initial begin
        rst = 1'b1;
        rate_sel = `ADFPM_RATE_QUAD;
        hpf_en = 1'b0;
        mod_valid = 1'b0;
        mod_data = 24'h000000;
        run = 1'b1;
        cur_rate = `ADFPM_RATE_QUAD;
        hpf_cur = 1'b0;
        do_reset;
        mute_phase(4000);
        run <= 1'b0;
        do_reset;
        mute_phase(8200);
        run <= 1'b1;
        for (g = 0; g < 12; g++)
            // First pass bypasses, second inserts the high-pass stage at every rate, then random
            group(g % 4, (g < 8) ? g[2] : ($random(seed) & 1), g == 5, g == 7);
        test_done;
    end
endmodule
